//--- design/dvgc_pkg.sv
// constants and types shared by the dual gain-control block
// assumes nothing of its surroundings; compiled before every module
package dvgc_pkg;

	// ==========================================================
	// gain code
	// ==========================================================
	localparam int         GAIN_W      = 6;      // code width
	localparam logic [5:0] GAIN_RESET  = 6'h3f;  // least gain at start
	localparam logic [5:0] GAIN_TOP    = 6'h3f;  // most attenuation
	localparam logic [5:0] GAIN_BOTTOM = 6'h00;  // least attenuation
	localparam logic [5:0] UPDN_BASE   = 6'h01;  // half a dB per code
	localparam logic [5:0] ATTACK_BASE = 6'h04;  // 2 dB in codes

	// ==========================================================
	// serial word layout
	// ==========================================================
	localparam int          WORD_W      = 16;       // word width
	localparam int          GAIN_LSB    = 0;        // gain bits 5:0
	localparam int          ATTACK_LSB  = 6;        // attack step 7:6
	localparam int          RW_BIT      = 15;       // read/write flag
	localparam logic [15:0] WORD_RESET  = 16'h003f; // gain 63, step 00
	localparam logic [4:0]  FRAME_BITS  = 5'h10;    // clocks per frame
	localparam logic [4:0]  FRAME_OVER  = 5'h11;    // too many clocks

	// ==========================================================
	// multifunction pin roles inside a channel's pin group
	// ==========================================================
	localparam int PIN_DIR    = 0;   // step direction
	localparam int PIN_CLK    = 1;   // step clock
	localparam int PIN_ATTACK = 2;   // fast attack trigger
	localparam int SYNC_W     = 25;  // all synchronised pins

	// ==========================================================
	// enumerations
	// ==========================================================
	typedef enum logic [1:0]
	{
		MODE_PAR  = 2'h0,
		MODE_SER  = 2'h1,
		MODE_UPDN = 2'h3
	} dvgc_mode_type;

	typedef enum logic [1:0]
	{
		FR_IDLE  = 2'h0,
		FR_WRITE = 2'h1,
		FR_READ  = 2'h3
	} dvgc_frame_type;

endpackage : dvgc_pkg

//--- design/dvgc_sync.sv
// two-flop synchroniser for a vector of unrelated pin levels
// assumes each bit is a slow level; no bus coherence is promised
`timescale 1ns/1ns
`default_nettype none
module dvgc_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             clkEn,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] synced
);

	// ==========================================================
	// checks
	// ==========================================================
	if (WIDTH < 1)
	begin : g_bad
		$error("dvgc_sync needs at least one bit");
	end

	logic [WIDTH-1:0] stage1;  // read by the second flop only

	// ==========================================================
	// flops
	// ==========================================================
	// both stages freeze with the clock enable
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage1 <= '0;
			synced <= '0;
		end
		else if (clkEn)
		begin
			stage1 <= pinIn;
			synced <= stage1;
		end
	end

endmodule : dvgc_sync
`default_nettype wire

//--- design/dvgc_updn_step.sv
// one channel's up/down stepper: edge finder, step and reset pattern
// assumes step clock and direction arrive already synchronised
`timescale 1ns/1ns
`default_nettype none
module dvgc_updn_step
	import dvgc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       clkEn,
	input  wire logic       enable,
	input  wire logic       stepClk,
	input  wire logic       stepDir,
	input  wire logic [1:0] stepSize,
	input  wire logic [5:0] curGain,
	output logic            stepValid,
	output logic      [5:0] stepCode
);

	// ==========================================================
	// state
	// ==========================================================
	logic       clkPrev;          // step clock one cycle ago
	logic       dirAtRise;        // direction caught on last rise
	logic       riseSeen;         // a rise happened in this mode
	logic       next_clkPrev;
	logic       next_dirAtRise;
	logic       next_riseSeen;
	logic       edgeRise;         // step clock went high
	logic       edgeFall;         // step clock went low
	logic [5:0] amount;           // codes per step

	// saturating move; up in gain means down in code
	function automatic logic [5:0] stepMove(input logic [5:0] cur,
		input logic [5:0] amt, input logic up);
		logic [6:0] sum;
		sum = {1'b0, cur} + {1'b0, amt};
		if (up)
			stepMove = (cur >= amt) ? cur - amt : GAIN_BOTTOM;
		else
			stepMove = sum[6] ? GAIN_TOP : sum[5:0];
	endfunction : stepMove

	// ==========================================================
	// next state
	// ==========================================================
	// both edges step; a falling edge whose direction differs from
	// the one caught on the rise is the reset pattern instead
	always_comb
	begin
		next_clkPrev   = stepClk;
		next_dirAtRise = dirAtRise;
		next_riseSeen  = riseSeen;
		edgeRise       = stepClk & ~clkPrev;
		edgeFall       = ~stepClk & clkPrev;
		amount         = UPDN_BASE << stepSize;
		stepValid      = 1'b0;
		stepCode       = curGain;
		if (!enable)
		begin
			// stale rises from another mode must not form a reset
			next_riseSeen = 1'b0;
		end
		else if (edgeRise)
		begin
			next_dirAtRise = stepDir;
			next_riseSeen  = 1'b1;
			stepValid      = 1'b1;
			stepCode       = stepMove(curGain, amount, stepDir);
		end
		else if (edgeFall)
		begin
			stepValid = 1'b1;
			if (riseSeen && (stepDir != dirAtRise))
				stepCode = GAIN_RESET;
			else
				stepCode = stepMove(curGain, amount, stepDir);
		end
	end

	// ==========================================================
	// flops
	// ==========================================================
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			clkPrev   <= 1'b0;
			dirAtRise <= 1'b0;
			riseSeen  <= 1'b0;
		end
		else if (clkEn)
		begin
			clkPrev   <= next_clkPrev;
			dirAtRise <= next_dirAtRise;
			riseSeen  <= next_riseSeen;
		end
	end

	// ==========================================================
	// checks
	// ==========================================================
	property p_upNoWrap;
		@(posedge clk) disable iff (!arst_n)
		stepValid && stepDir && !edgeFall |-> stepCode <= curGain;
	endproperty
	a_upNoWrap: assert property (p_upNoWrap)
		else $error("upward step raised the code");

	property p_resetPattern;
		@(posedge clk) disable iff (!arst_n)
		enable && edgeFall && riseSeen && (stepDir != dirAtRise)
		|-> stepValid && (stepCode == 6'h3f);
	endproperty
	a_resetPattern: assert property (p_resetPattern)
		else $error("reset pattern did not force code 63");

endmodule : dvgc_updn_step
`default_nettype wire

//--- design/dvgc_gain_ctrl.sv
// dual-channel gain-control logic: mode select, parallel latch,
// serial word with readback and fast attack, up/down stepping
// assumes every pin is asynchronous to clk and slow against it;
// the serial clock must stay under a quarter of the clk rate
//
// What this block does
// - two select pins pick parallel, serial, stepper
// - each channel holds a six-bit gain code
// - performance pin picks nominal or high performance
// - per-channel power-up pin enables that channel
// - shared pins routed by the selected interface
// - parallel mode: six-bit bus plus hold pin
// - transparent latch: gain follows parallel pins
// - closed latch: gain keeps captured value
// - hold low transparent, hold high closed
// - sixteen-bit word: gain, step, flag, spare
// - word bits zero to five hold gain
// - both selects low loads both channels
// - flag high arms sixteen-clock readback
// - attack step bits pick 2/4/8/16 dB
// - attack pin lowers gain by that step
// - each step-clock edge steps up or down
// - step-size pins pick 0.5/1/2/4 dB
// - stepping saturates at codes 0 and 63
// - opposite direction on rise/fall forces 63
// - code 0 is 20 dB, 0.5 dB steps
`timescale 1ns/1ns
`default_nettype none
module dvgc_gain_ctrl
	import dvgc_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire logic                    clkEn,
	input  wire logic                    ifaceSelLo,
	input  wire logic                    ifaceSelHi,
	input  wire logic                    perfModeSel,
	input  wire logic                    chanAPowerOn,
	input  wire logic                    chanBPowerOn,
	input  wire logic                    chanAHold,
	input  wire logic                    chanBHold,
	input  wire logic [5:0]              chanAParGain,
	input  wire logic [5:0]              chanBParGain,
	input  wire logic                    chanASelect_n,
	input  wire logic                    chanBSelect_n,
	input  wire logic                    serialClk,
	input  wire logic                    sdioIn,
	output logic                         sdioOut,
	output logic                         sdioOe_n,
	input  wire logic                    stepSizeHi,
	input  wire logic                    stepSizeLo,
	output logic      [5:0]              chanAGain,
	output logic      [5:0]              chanBGain,
	output logic                         chanAActive,
	output logic                         chanBActive,
	output logic                         perfHigh,
	output dvgc_pkg::dvgc_mode_type      ifaceMode
);

	// ==========================================================
	// synchronised pins
	// ==========================================================
	logic [SYNC_W-1:0] syncOut;     // all pins after two flops
	logic              sIfHi;       // upper interface select
	logic              sIfLo;       // lower interface select
	logic              sPerf;       // performance pin
	logic              sPwrA;       // channel a power-up
	logic              sPwrB;       // channel b power-up
	logic              sHold [2];   // hold pins
	logic [5:0]        sPar  [2];   // multifunction pin groups
	logic [1:0]        selLow;      // selects, active high here
	logic              sSelAn;      // channel a select, raw level
	logic              sSelBn;      // channel b select, raw level
	logic              sSclk;       // serial clock level
	logic              sSdio;       // serial data in
	logic [1:0]        sStep;       // step-size pins

	dvgc_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.clkEn  (clkEn),
		.pinIn  ({ifaceSelHi, ifaceSelLo, perfModeSel, chanAPowerOn,
			chanBPowerOn, chanAHold, chanBHold, chanAParGain,
			chanBParGain, chanASelect_n, chanBSelect_n, serialClk,
			sdioIn, stepSizeHi, stepSizeLo}),
		.synced (syncOut)
	);

	assign {sIfHi, sIfLo, sPerf, sPwrA, sPwrB, sHold[0], sHold[1],
		sPar[0], sPar[1], sSelAn, sSelBn, sSclk, sSdio,
		sStep} = syncOut;
	assign selLow = {~sSelBn, ~sSelAn};

	// pins common to all interfaces go straight out of flops
	assign perfHigh    = sPerf;
	assign chanAActive = sPwrA;
	assign chanBActive = sPwrB;

	// ==========================================================
	// interface select
	// ==========================================================
	dvgc_mode_type mode;       // registered interface
	dvgc_mode_type next_mode;

	// upper select alone decides stepper mode
	always_comb
	begin
		if (sIfHi)
			next_mode = MODE_UPDN;
		else if (sIfLo)
			next_mode = MODE_SER;
		else
			next_mode = MODE_PAR;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			mode <= MODE_PAR;
		else if (clkEn)
			mode <= next_mode;
	end

	assign ifaceMode = mode;

	// ==========================================================
	// serial frame
	// ==========================================================
	dvgc_frame_type frame;            // frame in progress
	dvgc_frame_type next_frame;
	logic [4:0]     bitCnt;           // rising clocks this frame
	logic [4:0]     next_bitCnt;
	logic [15:0]    shiftIn;          // incoming word, msb first
	logic [15:0]    next_shiftIn;
	logic [1:0]     frameSel;         // channels selected in frame
	logic [1:0]     next_frameSel;
	logic [15:0]    word [2];         // stored word per channel
	logic [15:0]    next_word [2];
	logic [1:0]     readArm;          // readback pending
	logic [1:0]     next_readArm;
	logic           rdCh;             // channel being read
	logic           next_rdCh;
	logic [15:0]    readShift;        // outgoing word
	logic [15:0]    next_readShift;
	logic           oeN;              // data pin driver, active low
	logic           next_oeN;
	logic [1:0]     loadPulse;        // word accepted, apply gain
	logic [1:0]     next_loadPulse;
	logic           sclkPrev;         // serial clock one cycle ago
	logic           sclkRise;
	logic           sclkFall;
	logic           serMode;

	assign serMode  = (mode == MODE_SER);
	assign sclkRise = sSclk & ~sclkPrev;
	assign sclkFall = ~sSclk & sclkPrev;
	assign sdioOut  = readShift[WORD_W-1];
	assign sdioOe_n = oeN;

	// a frame runs from the first select falling to both high;
	// anything other than exactly sixteen clocks is dropped
	always_comb
	begin
		next_frame     = frame;
		next_bitCnt    = bitCnt;
		next_shiftIn   = shiftIn;
		next_frameSel  = frameSel;
		next_word      = word;
		next_readArm   = readArm;
		next_rdCh      = rdCh;
		next_readShift = readShift;
		next_loadPulse = 2'h0;
		case (frame)
			FR_IDLE:
			begin
				if (serMode && (selLow != 2'h0))
				begin
					next_bitCnt   = 5'h00;
					next_frameSel = selLow;
					// one channel only may answer the shared line
					if (selLow[0] && readArm[0])
					begin
						next_frame     = FR_READ;
						next_rdCh      = 1'b0;
						next_readShift = word[0];
					end
					else if (selLow[1] && readArm[1])
					begin
						next_frame     = FR_READ;
						next_rdCh      = 1'b1;
						next_readShift = word[1];
					end
					else
						next_frame = FR_WRITE;
				end
			end
			FR_WRITE:
			begin
				if (!serMode)
					next_frame = FR_IDLE;
				else if (selLow == 2'h0)
				begin
					next_frame = FR_IDLE;
					if (bitCnt == FRAME_BITS)
					begin
						if (shiftIn[RW_BIT])
							next_readArm = readArm | frameSel;
						else
						begin
							for (int i = 0; i < 2; i++)
							begin
								// every selected channel takes it
								if (frameSel[i])
								begin
									next_word[i] = {1'b0,
										shiftIn[RW_BIT-1:0]};
									next_loadPulse[i] = 1'b1;
								end
							end
						end
					end
				end
				else
				begin
					next_frameSel = frameSel | selLow;
					if (sclkRise)
					begin
						next_shiftIn = {shiftIn[WORD_W-2:0], sSdio};
						if (bitCnt != FRAME_OVER)
							next_bitCnt = bitCnt + 5'h01;
					end
				end
			end
			FR_READ:
			begin
				if (!serMode)
					next_frame = FR_IDLE;
				else if (selLow == 2'h0)
				begin
					next_frame = FR_IDLE;
					// a short read leaves the readback armed
					if (bitCnt == FRAME_BITS)
						next_readArm[rdCh] = 1'b0;
				end
				else
				begin
					if (sclkRise && (bitCnt != FRAME_OVER))
						next_bitCnt = bitCnt + 5'h01;
					// master samples on rise, so change on fall
					if (sclkFall)
						next_readShift = {readShift[WORD_W-2:0],
							1'b0};
				end
			end
			default:
				next_frame = FR_IDLE;
		endcase
		next_oeN = (next_frame != FR_READ);
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			frame     <= FR_IDLE;
			bitCnt    <= 5'h00;
			shiftIn   <= 16'h0000;
			frameSel  <= 2'h0;
			word[0]   <= WORD_RESET;
			word[1]   <= WORD_RESET;
			readArm   <= 2'h0;
			rdCh      <= 1'b0;
			readShift <= 16'h0000;
			oeN       <= 1'b1;
			loadPulse <= 2'h0;
			sclkPrev  <= 1'b0;
		end
		else if (clkEn)
		begin
			frame     <= next_frame;
			bitCnt    <= next_bitCnt;
			shiftIn   <= next_shiftIn;
			frameSel  <= next_frameSel;
			word      <= next_word;
			readArm   <= next_readArm;
			rdCh      <= next_rdCh;
			readShift <= next_readShift;
			oeN       <= next_oeN;
			loadPulse <= next_loadPulse;
			sclkPrev  <= sSclk;
		end
	end

	// ==========================================================
	// up/down steppers, one per channel
	// ==========================================================
	logic [1:0] stepValid;       // a step edge this cycle
	logic [5:0] stepCode [2];    // code after that step
	logic [5:0] gain [2];        // held gain codes
	logic [5:0] next_gain [2];

	for (genvar g = 0; g < 2; g++)
	begin : g_step
		// pin roles switch with the mode
		dvgc_updn_step u_step (
			.clk       (clk),
			.arst_n    (arst_n),
			.clkEn     (clkEn),
			.enable    (mode == MODE_UPDN),
			.stepClk   (sPar[g][PIN_CLK]),
			.stepDir   (sPar[g][PIN_DIR]),
			.stepSize  (sStep),
			.curGain   (gain[g]),
			.stepValid (stepValid[g]),
			.stepCode  (stepCode[g])
		);
	end

	// ==========================================================
	// gain codes
	// ==========================================================
	logic [1:0] trigPrev;        // attack pin one cycle ago
	logic [1:0] next_trigPrev;
	logic [1:0] attackRise;      // attack pin went high
	logic [6:0] attackSum;       // wide sum to catch overflow
	logic [5:0] attackAmt;       // attack step in codes

	// one attack step per rising trigger, so a held pin does not
	// ramp the channel down to the bottom of the range
	always_comb
	begin
		attackSum = 7'h00;
		attackAmt = 6'h00;
		for (int i = 0; i < 2; i++)
		begin
			next_gain[i]     = gain[i];
			next_trigPrev[i] = sPar[i][PIN_ATTACK];
			attackRise[i]    = sPar[i][PIN_ATTACK] & ~trigPrev[i];
			case (mode)
				MODE_PAR:
				begin
					if (!sHold[i])
						next_gain[i] = sPar[i];
				end
				MODE_SER:
				begin
					if (loadPulse[i])
						next_gain[i] = word[i][GAIN_LSB +: GAIN_W];
					else if (attackRise[i])
					begin
						attackAmt = ATTACK_BASE <<
							word[i][ATTACK_LSB +: 2];
						attackSum = {1'b0, gain[i]} + {1'b0, attackAmt};
						next_gain[i] = attackSum[6] ? GAIN_TOP
							: attackSum[5:0];
					end
				end
				MODE_UPDN:
				begin
					if (stepValid[i])
						next_gain[i] = stepCode[i];
				end
				default:
					next_gain[i] = gain[i];
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gain[0]  <= GAIN_RESET;
			gain[1]  <= GAIN_RESET;
			trigPrev <= 2'h0;
		end
		else if (clkEn)
		begin
			gain     <= next_gain;
			trigPrev <= next_trigPrev;
		end
	end

	// code 0 is the highest gain; the analog side maps it
	assign chanAGain = gain[0];
	assign chanBGain = gain[1];

	// ==========================================================
	// checks
	// ==========================================================
	property p_modeHi;
		@(posedge clk) disable iff (!arst_n)
		clkEn && sIfHi |=> mode == MODE_UPDN;
	endproperty
	a_modeHi: assert property (p_modeHi)
		else $error("upper select did not pick the stepper");

	property p_transparent;
		@(posedge clk) disable iff (!arst_n)
		clkEn && mode == MODE_PAR && !sHold[0]
		|=> gain[0] == $past(sPar[0]);
	endproperty
	a_transparent: assert property (p_transparent)
		else $error("open latch did not follow the pins");

	property p_latched;
		@(posedge clk) disable iff (!arst_n)
		mode == MODE_PAR && sHold[1] |=> gain[1] == $past(gain[1]);
	endproperty
	a_latched: assert property (p_latched)
		else $error("closed latch let the gain move");

	property p_loadAtEnd;
		@(posedge clk) disable iff (!arst_n)
		loadPulse[0] |-> $past(frame) == FR_WRITE
			&& $past(bitCnt) == 5'h10 && frame == FR_IDLE;
	endproperty
	a_loadAtEnd: assert property (p_loadAtEnd)
		else $error("gain loaded outside a full frame end");

	property p_bothLoad;
		@(posedge clk) disable iff (!arst_n)
		loadPulse[0] && $past(frameSel) == 2'h3 |-> loadPulse[1];
	endproperty
	a_bothLoad: assert property (p_bothLoad)
		else $error("dual select loaded one channel only");

	property p_readDrive;
		@(posedge clk) disable iff (!arst_n)
		(frame == FR_READ) |-> !sdioOe_n ##1 (frame != FR_READ
			|| !sdioOe_n);
	endproperty
	a_readDrive: assert property (p_readDrive)
		else $error("data pin not driven during readback");

	property p_attackClamp;
		@(posedge clk) disable iff (!arst_n)
		clkEn && serMode && attackRise[0] && !loadPulse[0]
		|=> gain[0] >= $past(gain[0]) && gain[0] != $past(gain[0])
			|| $past(gain[0]) == 6'h3f;
	endproperty
	a_attackClamp: assert property (p_attackClamp)
		else $error("fast attack wrapped or did not move");

endmodule : dvgc_gain_ctrl
`default_nettype wire

//--- verification/dvgc_master_model.sv
// serial master model: selects, serial clock, data line
// assumes the bench resolves the shared line from the device enable
`timescale 1ns/1ns
`default_nettype none
module dvgc_master_model
(
	input  wire logic clk,
	input  wire logic line,
	output logic      selA_n,
	output logic      selB_n,
	output logic      sclk,
	output logic      sdio
);
	// ==========
	// idle state
	// ==========
	// clock parked low between frames
	initial
	begin
		{selA_n, selB_n, sclk, sdio} = 4'hc;
	end
	// one whole frame, 16 clocks of 64 ns, msb first
	task automatic xfer(input logic [15:0] w, input logic [1:0] sel,
		input logic rd, output logic [15:0] r);
		int i;
		@(negedge clk);
		{selB_n, selA_n} = ~sel;
		repeat (8) @(negedge clk);
		for (i = 15; i >= 0; i--)
		begin
			// released line toggles so no stale value passes
			sdio = rd ? ~sdio : w[i];
			repeat (8) @(negedge clk);
			r[i] = line;
			sclk = 1'h1;
			repeat (8) @(negedge clk);
			sclk = 1'h0;
		end
		repeat (8) @(negedge clk);
		{selB_n, selA_n} = 2'h3;
		repeat (8) @(negedge clk);
	endtask : xfer
endmodule : dvgc_master_model
`default_nettype wire

//--- verification/dvgc_gain_ctrl_test.sv
// self-checking bench for the dual gain-control block
// assumes the master model drives the serial port
`timescale 1ns/1ns
`default_nettype none
module dvgc_gain_ctrl_test;
	import dvgc_pkg::*;
	// ==========
	// signals
	// ==========
	typedef struct packed
	{
		logic [2:0] pin;  // perf, power a, power b
		logic       hold; // latch closed when high
		logic [5:0] par;  // bus value
		logic [5:0] gain; // expected code
	} dvgc_row_type;
	logic clk, arst_n, selLo, selHi, perf, pwrA, pwrB, holdA, holdB;
	logic szHi, szLo, selA_n, selB_n, sclk, sdio, line, sdioOut;
	logic sdioOe_n, actA, actB, perfHi, clkEn;
	logic [5:0] parA, parB, gainA, gainB, want;
	logic [15:0] rd;
	dvgc_mode_type mode;
	int errors, testsRun, i;
	// hold row closes first, then the bus moves
	dvgc_row_type rows [4] = '{'{3'h7, 1'h0, 6'h15, 6'h15},
		'{3'h2, 1'h1, 6'h2a, 6'h15}, '{3'h5, 1'h0, 6'h2a, 6'h2a},
		'{3'h0, 1'h0, 6'h00, 6'h00}};
	// device wins the line only while it enables
	assign line = !sdioOe_n ? sdioOut : sdio;
	dvgc_gain_ctrl i_dvgc_gain_ctrl (.clk(clk), .arst_n(arst_n),
		.clkEn(clkEn), .ifaceSelLo(selLo), .ifaceSelHi(selHi),
		.perfModeSel(perf), .chanAPowerOn(pwrA), .chanBPowerOn(pwrB),
		.chanAHold(holdA), .chanBHold(holdB), .chanAParGain(parA),
		.chanBParGain(parB), .chanASelect_n(selA_n),
		.chanBSelect_n(selB_n), .serialClk(sclk), .sdioIn(line),
		.sdioOut(sdioOut), .sdioOe_n(sdioOe_n), .stepSizeHi(szHi),
		.stepSizeLo(szLo), .chanAGain(gainA), .chanBGain(gainB),
		.chanAActive(actA), .chanBActive(actB), .perfHigh(perfHi),
		.ifaceMode(mode));
	dvgc_master_model i_dvgc_master_model (.clk(clk), .line(line),
		.selA_n(selA_n), .selB_n(selB_n), .sclk(sclk), .sdio(sdio));
	// ==========
	// helpers
	// ==========
	task automatic chkGain(input logic [5:0] got, input logic [5:0] e);
		testsRun++;
		if (got !== e)
		begin
			errors++;
			$display("unexpected at %0t: gain %h not %h", $time, got, e);
		end
	endtask : chkGain
	task automatic chkWord(input logic [15:0] got, input logic [15:0] e);
		testsRun++;
		if (got !== e)
		begin
			errors++;
			$display("unexpected at %0t: word %h not %h", $time, got, e);
		end
	endtask : chkWord
	// one step-clock level, long enough to be synced
	task automatic stepEdge(input logic v);
		parA[1] = v;
		repeat (6) @(negedge clk);
	endtask : stepEdge
	task automatic complete_run;
		$display("checks %0d mismatches %0d", testsRun, errors);
		if (errors == 0 && testsRun > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	// ==========
	// processes
	// ==========
	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// hang guard, far beyond the roughly 1400 cycles used
	initial
	begin
		#100000;
		errors++;
		complete_run;
	end
	initial
	begin
		{selLo, selHi, perf, pwrA, pwrB, holdA, holdB} = 7'h0;
		clkEn = 1'h1;
		{parA, parB, szHi, szLo, arst_n} = 15'h0;
		repeat (12) @(negedge clk);
		chkGain(gainA, GAIN_RESET);
		chkWord({sdioOe_n, mode}, 3'h4);
		arst_n = 1'h1;
		$display("reset test done");
		for (i = 0; i < 4; i++)
		begin
			{perf, pwrA, pwrB} = rows[i].pin;
			{holdA, holdB} = {2{rows[i].hold}};
			repeat (4) @(negedge clk);
			{parA, parB} = {2{rows[i].par}};
			repeat (6) @(negedge clk);
			chkGain(gainA, rows[i].gain);
			chkGain(gainB, rows[i].gain);
			chkWord({perfHi, actA, actB}, rows[i].pin);
		end
		chkWord(mode, MODE_PAR);
		$display("parallel test done");
		selLo = 1'h1;
		repeat (6) @(negedge clk);
		chkWord(mode, MODE_SER);
		i_dvgc_master_model.xfer(16'h0045, 2'h3, 1'h0, rd);
		repeat (8) @(negedge clk);
		chkGain(gainA, 6'h05);
		chkGain(gainB, 6'h05);
		i_dvgc_master_model.xfer(16'h8000, 2'h1, 1'h0, rd);
		i_dvgc_master_model.xfer(16'h0000, 2'h1, 1'h1, rd);
		chkWord(rd, 16'h0045);
		parA = 6'h04;
		repeat (8) @(negedge clk);
		chkGain(gainA, 6'h0d);
		chkGain(gainB, 6'h05);
		parA = 6'h00;
		// a write after readback shows write mode came back
		i_dvgc_master_model.xfer(16'h00fa, 2'h1, 1'h0, rd);
		repeat (8) @(negedge clk);
		parA = 6'h04;
		repeat (8) @(negedge clk);
		chkGain(gainA, 6'h3f);
		chkGain(gainB, 6'h05);
		$display("serial test done");
		parA = 6'h01;
		{selHi, selLo} = 2'h3;
		repeat (6) @(negedge clk);
		chkWord(mode, MODE_UPDN);
		selLo = 1'h0;
		repeat (6) @(negedge clk);
		chkWord(mode, MODE_UPDN);
		want = 6'h3f;
		for (i = 0; i < 4; i++)
		begin
			{szHi, szLo} = i[1:0];
			repeat (4) @(negedge clk);
			stepEdge(1'h1);
			stepEdge(1'h0);
			want = want - 6'(2 << i);
			chkGain(gainA, want);
		end
		repeat (3)
		begin
			stepEdge(1'h1);
			stepEdge(1'h0);
		end
		chkGain(gainA, 6'h00);
		parA[0] = 1'h0;
		repeat (4) @(negedge clk);
		stepEdge(1'h1);
		chkGain(gainA, 6'h08);
		parA[0] = 1'h1;
		repeat (4) @(negedge clk);
		stepEdge(1'h0);
		chkGain(gainA, 6'h3f);
		$display("stepper test done");
		// frozen clock enable: a whole step pulse must leave no trace
		clkEn = 1'h0;
		stepEdge(1'h1);
		stepEdge(1'h0);
		clkEn = 1'h1;
		repeat (4) @(negedge clk);
		chkGain(gainA, 6'h3f);
		$display("clock enable test done");
		arst_n = 1'h0;
		repeat (2) @(negedge clk);
		chkGain(gainB, GAIN_RESET);
		arst_n = 1'h1;
		$display("second reset test done");
		complete_run;
	end
endmodule : dvgc_gain_ctrl_test
`default_nettype wire
